// ### rtl/timer_regs.vh
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// register indices on the 4-bit address port
`define REG_CTRL_ONE 4'h0
`define REG_CTRL_FIVE 4'h1
`define REG_CTRL_SIX 4'h2
`define REG_EVT_CTRL 4'h3
`define REG_INT_FLAGS 4'h4
`define REG_COUNTER 4'h5
`define REG_PERIOD 4'h6
`define REG_PERIOD_BUF 4'h7
`define REG_CMP0 4'h8
`define REG_CMP1 4'h9
`define REG_CMP2 4'ha
`define REG_CMPBUF0 4'hb
`define REG_CMPBUF1 4'hc
`define REG_CMPBUF2 4'hd

// control_reg_one fields
`define BIT_ENABLE 0
`define SEL_LSB 1
`define SEL_MSB 3
`define BIT_SPLIT 4
// control_reg_five fields
`define BIT_DIR 0
`define BIT_LOCK_UPD 1
`define BIT_UPD_BOTTOM 2
// control_reg_six fields (read only)
`define BIT_PERIOD_BUFFER_VALID 0
`define CMPBV_LSB 1
`define CMPBV_MSB 3
`define BIT_MAX 4
// event_control_reg fields
`define BIT_EVT_COUNT 0
`define BIT_EVT_DIR 1
`define BIT_EVT_RESTART 2
// interrupt flag fields
`define FLG_TOP 0
`define FLG_BOTTOM 1
`define FLG_CMP_LO 2
`define FLG_CMP_HI 5

// reset values
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define PERIOD_RST 16'hffff
`define ONE16 16'h0001
`define ONE8 8'h01

// prescaler masks: divide by 1,2,4,8,16,64,256,1024
`define PS_DIV1 10'h000
`define PS_DIV2 10'h001
`define PS_DIV4 10'h003
`define PS_DIV8 10'h007
`define PS_DIV16 10'h00f
`define PS_DIV64 10'h03f
`define PS_DIV256 10'h0ff
`define PS_DIV1024 10'h3ff
`define PS_ONE 10'h001
`define PS_ZERO 10'h000

`endif

// ### rtl/buffered_base_timer_counter.v
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "timer_regs.vh"

module buffered_base_timer_counter (
    input wire ref_clk,
    input wire resetn,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_r,
    input wire event_count_in,
    input wire event_dir_in,
    input wire event_restart_in,
    output reg top_event_r,
    output reg bottom_event_r,
    output reg [5:0] compare_event_r
);

    // the block is one clock domain: every slower rate is a tick
    // enable derived from the free prescaler or from an event edge,
    // so no signal crosses between clocks
    //
    // software sees fourteen sixteen-bit registers; reserved bits
    // read as zero and unmapped indices ignore writes
    //
    // prescaler mask for a given clock_prescale_select value
    // a tick fires when all masked prescaler bits are one, which
    // gives divide ratios that are powers of two
    function [9:0] presc_mask;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: presc_mask = `PS_DIV1;
                3'h1: presc_mask = `PS_DIV2;
                3'h2: presc_mask = `PS_DIV4;
                3'h3: presc_mask = `PS_DIV8;
                3'h4: presc_mask = `PS_DIV16;
                3'h5: presc_mask = `PS_DIV64;
                3'h6: presc_mask = `PS_DIV256;
                default: presc_mask = `PS_DIV1024;
            endcase
        end
    endfunction

    // write hit on a given register index
    // shared by every register so the decode stays uniform
    function wr_hit;
        input [3:0] addr;
        input [3:0] idx;
        input wr;
        begin
            wr_hit = wr && (addr == idx);
        end
    endfunction

    // control state
    reg enable_r; // counter running
    reg [2:0] clock_prescale_select_r; // prescaler choice
    reg split_r; // two 8-bit counters
    reg count_direction_r; // 1 = down
    reg lock_update_r; // blocks buffer copies
    reg update_at_bottom_r; // update at bottom, else top
    reg event_count_input_enable_r; // count events
    reg evt_dir_en_r; // event level flips direction
    reg evt_restart_en_r; // event restarts counter
    reg [7:0] flags_r; // sticky interrupt flags
    // counting state
    reg [9:0] presc_cnt_r; // free prescaler
    reg evt_prev_r; // previous event level
    reg [15:0] counter_value_r;
    reg [15:0] period_r;
    reg [15:0] period_buffer_r;
    reg period_buffer_valid_r;
    reg [15:0] compare_value_r [0:2];
    reg [15:0] compare_buffer_r [0:2];
    reg [2:0] compare_buffer_valid_r;
    reg [15:0] rdata_nxt; // read mux
    reg [15:0] counter_nxt; // next counter
    reg [7:0] flag_set; // events this cycle
    reg [2:0] hit_lo; // compare matches, low/full
    reg [2:0] hit_hi; // compare matches, high byte
    integer i; // loop index of the clocked register block
    integer j; // loop index of the compare match decode

    // timing summary:
    // a tick edge raises flags for the value held before the tick,
    // and the one-cycle event pulses are registered on that same edge, so a
    // match or boundary shows on the following tick as required
    //
    // the update condition is judged on the same tick edge, and the
    // copied period or compare values take part from the next count
    //
    // a software counter write beats a restart, which beats a tick

    wire [9:0] mask = presc_mask(clock_prescale_select_r);
    // prescaled clock tick
    wire clk_tick = (presc_cnt_r & mask) == mask;
    // rising edge of the counting event
    wire evt_edge = event_count_in & ~evt_prev_r;
    // tick only while enabled, source per enable bit
    wire tick = enable_r &&
        (event_count_input_enable_r ? evt_edge : clk_tick);
    // direction, optionally steered by an event level
    wire down = evt_dir_en_r ? (count_direction_r ^ event_dir_in)
                             : count_direction_r;
    // restart event clears the counter
    wire restart = enable_r && evt_restart_en_r && event_restart_in;
    // boundary detection
    wire at_bottom = counter_value_r == `ZERO16;
    wire at_max = &counter_value_r;
    wire at_top = counter_value_r == period_r;
    // split mode byte boundaries
    wire lo_zero = counter_value_r[7:0] == `ZERO8;
    wire hi_zero = counter_value_r[15:8] == `ZERO8;
    // update condition on a tick at top or bottom
    wire update = tick && !split_r &&
        (update_at_bottom_r ? at_bottom : at_top);
    wire do_copy = update && !lock_update_r;
    // software writes
    wire wr_cnt = wr_hit(reg_addr, `REG_COUNTER, reg_wr);
    wire wr_pbuf = wr_hit(reg_addr, `REG_PERIOD_BUF, reg_wr);
    wire wr_flags = wr_hit(reg_addr, `REG_INT_FLAGS, reg_wr);

    // compare matches against each channel
    // in split mode each byte is matched against its own byte of the
    // compare value; otherwise the high-byte matches stay quiet
    always @* begin
        for (j = 0; j < 3; j = j + 1) begin
            if (split_r) begin
                hit_lo[j] = counter_value_r[7:0] ==
                    compare_value_r[j][7:0];
                hit_hi[j] = counter_value_r[15:8] ==
                    compare_value_r[j][15:8];
            end else begin
                hit_lo[j] = counter_value_r == compare_value_r[j];
                hit_hi[j] = 1'b0;
            end
        end
    end

    // flags raised for the value held while the next tick arrives
    always @* begin
        flag_set = 8'h00;
        if (tick) begin
            if (split_r) begin
                flag_set[`FLG_TOP] = lo_zero;
                flag_set[`FLG_BOTTOM] = hi_zero;
            end else begin
                flag_set[`FLG_TOP] = at_top;
                flag_set[`FLG_BOTTOM] = at_bottom;
            end
            flag_set[`FLG_CMP_LO+2:`FLG_CMP_LO] = hit_lo;
            flag_set[`FLG_CMP_HI+2:`FLG_CMP_HI] = hit_hi;
        end
    end

    // next counter value, software write has priority
    always @* begin
        counter_nxt = counter_value_r;
        if (wr_cnt) begin
            counter_nxt = reg_wdata;
        end else if (restart) begin
            counter_nxt = `ZERO16;
        end else if (tick && split_r) begin
            // two 8-bit down counters
            if (lo_zero) begin
                counter_nxt[7:0] = period_r[7:0];
            end else begin
                counter_nxt[7:0] = counter_value_r[7:0] - `ONE8;
            end
            if (hi_zero) begin
                counter_nxt[15:8] = period_r[15:8];
            end else begin
                counter_nxt[15:8] = counter_value_r[15:8] - `ONE8;
            end
        end else if (tick && down) begin
            if (at_bottom) begin
                counter_nxt = period_r;
            end else begin
                counter_nxt = counter_value_r - `ONE16;
            end
        end else if (tick) begin
            if (at_top) begin
                counter_nxt = `ZERO16;
            end else begin
                counter_nxt = counter_value_r + `ONE16;
            end
        end
    end

    // read mux
    // the selected word is registered only while a read strobe is
    // high, so the bus shows zero in every other cycle
    always @* begin
        rdata_nxt = `ZERO16;
        if (reg_addr == `REG_CTRL_ONE) begin
            rdata_nxt[`BIT_ENABLE] = enable_r;
            rdata_nxt[`SEL_MSB:`SEL_LSB] = clock_prescale_select_r;
            rdata_nxt[`BIT_SPLIT] = split_r;
        end else if (reg_addr == `REG_CTRL_FIVE) begin
            rdata_nxt[`BIT_DIR] = count_direction_r;
            rdata_nxt[`BIT_LOCK_UPD] = lock_update_r;
            rdata_nxt[`BIT_UPD_BOTTOM] = update_at_bottom_r;
        end else if (reg_addr == `REG_CTRL_SIX) begin
            rdata_nxt[`BIT_PERIOD_BUFFER_VALID] = period_buffer_valid_r;
            rdata_nxt[`CMPBV_MSB:`CMPBV_LSB] = compare_buffer_valid_r;
            rdata_nxt[`BIT_MAX] = at_max;
        end else if (reg_addr == `REG_EVT_CTRL) begin
            rdata_nxt[`BIT_EVT_COUNT] = event_count_input_enable_r;
            rdata_nxt[`BIT_EVT_DIR] = evt_dir_en_r;
            rdata_nxt[`BIT_EVT_RESTART] = evt_restart_en_r;
        end else if (reg_addr == `REG_INT_FLAGS) begin
            rdata_nxt[7:0] = flags_r;
        end else if (reg_addr == `REG_COUNTER) begin
            rdata_nxt = counter_value_r;
        end else if (reg_addr == `REG_PERIOD) begin
            rdata_nxt = period_r;
        end else if (reg_addr == `REG_PERIOD_BUF) begin
            rdata_nxt = period_buffer_r;
        end else if (reg_addr == `REG_CMP0) begin
            rdata_nxt = compare_value_r[0];
        end else if (reg_addr == `REG_CMP1) begin
            rdata_nxt = compare_value_r[1];
        end else if (reg_addr == `REG_CMP2) begin
            rdata_nxt = compare_value_r[2];
        end else if (reg_addr == `REG_CMPBUF0) begin
            rdata_nxt = compare_buffer_r[0];
        end else if (reg_addr == `REG_CMPBUF1) begin
            rdata_nxt = compare_buffer_r[1];
        end else if (reg_addr == `REG_CMPBUF2) begin
            rdata_nxt = compare_buffer_r[2];
        end
    end

    // control registers, bus answer and event outputs
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enable_r <= 1'b0;
            clock_prescale_select_r <= 3'h0;
            split_r <= 1'b0;
            count_direction_r <= 1'b0;
            lock_update_r <= 1'b0;
            update_at_bottom_r <= 1'b0;
            event_count_input_enable_r <= 1'b0;
            evt_dir_en_r <= 1'b0;
            evt_restart_en_r <= 1'b0;
            flags_r <= 8'h00;
            reg_rdata_r <= `ZERO16;
            top_event_r <= 1'b0;
            bottom_event_r <= 1'b0;
            compare_event_r <= 6'h00;
            presc_cnt_r <= `PS_ZERO;
            evt_prev_r <= 1'b0;
        end else begin
            // read data valid only in the cycle after the strobe
            reg_rdata_r <= reg_rd ? rdata_nxt : `ZERO16;
            if (wr_hit(reg_addr, `REG_CTRL_ONE, reg_wr)) begin
                enable_r <= reg_wdata[`BIT_ENABLE];
                clock_prescale_select_r <=
                    reg_wdata[`SEL_MSB:`SEL_LSB];
                split_r <= reg_wdata[`BIT_SPLIT];
            end
            if (wr_hit(reg_addr, `REG_CTRL_FIVE, reg_wr)) begin
                count_direction_r <= reg_wdata[`BIT_DIR];
                lock_update_r <= reg_wdata[`BIT_LOCK_UPD];
                update_at_bottom_r <= reg_wdata[`BIT_UPD_BOTTOM];
            end
            if (wr_hit(reg_addr, `REG_EVT_CTRL, reg_wr)) begin
                event_count_input_enable_r <=
                    reg_wdata[`BIT_EVT_COUNT];
                evt_dir_en_r <= reg_wdata[`BIT_EVT_DIR];
                evt_restart_en_r <= reg_wdata[`BIT_EVT_RESTART];
            end
            // write one clears a flag, a new event wins
            if (wr_flags) begin
                flags_r <= (flags_r & ~reg_wdata[7:0]) | flag_set;
            end else begin
                flags_r <= flags_r | flag_set;
            end
            // one-cycle event pulses
            top_event_r <= flag_set[`FLG_TOP];
            bottom_event_r <= flag_set[`FLG_BOTTOM];
            compare_event_r <= {flag_set[`FLG_CMP_HI+2:`FLG_CMP_HI],
                                flag_set[`FLG_CMP_LO+2:`FLG_CMP_LO]};
            // prescaler runs only while enabled
            if (enable_r) begin
                presc_cnt_r <= presc_cnt_r + `PS_ONE;
            end else begin
                presc_cnt_r <= `PS_ZERO;
            end
            evt_prev_r <= event_count_in;
        end
    end

    // counter, period and compare registers with buffers
    // a direct write to period or compare wins over the copy, and a
    // buffer write in the update cycle keeps its data and its valid
    // flag, but a direct period or compare write in that cycle drops the pending buffered value
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            counter_value_r <= `ZERO16;
            period_r <= `PERIOD_RST;
            period_buffer_r <= `ZERO16;
            period_buffer_valid_r <= 1'b0;
            compare_buffer_valid_r <= 3'h0;
            for (i = 0; i < 3; i = i + 1) begin
                compare_value_r[i] <= `ZERO16;
                compare_buffer_r[i] <= `ZERO16;
            end
        end else begin
            counter_value_r <= counter_nxt;
            // direct period write bypasses the buffer
            if (wr_hit(reg_addr, `REG_PERIOD, reg_wr)) begin
                period_r <= reg_wdata;
            end else if (do_copy && period_buffer_valid_r) begin
                period_r <= period_buffer_r;
            end
            if (wr_pbuf) begin
                period_buffer_r <= reg_wdata;
            end
            // buffer write sets valid and wins over the clear
            if (wr_pbuf) begin
                period_buffer_valid_r <= 1'b1;
            end else if (do_copy) begin
                period_buffer_valid_r <= 1'b0;
            end
            for (i = 0; i < 3; i = i + 1) begin
                // compare and buffer both writable
                if (wr_hit(reg_addr, `REG_CMP0 + i[3:0], reg_wr)) begin
                    compare_value_r[i] <= reg_wdata;
                end else if (do_copy && compare_buffer_valid_r[i]) begin
                    compare_value_r[i] <= compare_buffer_r[i];
                end
                if (wr_hit(reg_addr, `REG_CMPBUF0 + i[3:0],
                           reg_wr)) begin
                    compare_buffer_r[i] <= reg_wdata;
                    compare_buffer_valid_r[i] <= 1'b1;
                end else if (do_copy) begin
                    compare_buffer_valid_r[i] <= 1'b0;
                end
            end
        end
    end

endmodule

// ### tb/timer_chk.sv
`include "timer_regs.vh"
module timer_chk (
    input wire ref_clk,
    input wire resetn,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata_r,
    input wire top_event_r,
    input wire bottom_event_r,
    input wire [5:0] compare_event_r
);
    timeunit 1ns;
    timeprecision 1ps;
    reg en_r; // shadow of the enable bit
    // follow software writes of the enable bit
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            en_r <= 1'b0;
        end else if (reg_wr && reg_addr == `REG_CTRL_ONE) begin
            en_r <= reg_wdata[`BIT_ENABLE];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    // a write directly followed by a read of the same index
    sequence wr_then_rd;
        reg_wr ##1 reg_rd && reg_addr == $past(reg_addr);
    endsequence
    // two counter reads two cycles apart while stopped
    sequence cnt_rd_pair;
        (reg_rd && reg_addr == `REG_COUNTER && !en_r && !$past(en_r))
            ##2 (reg_rd && reg_addr == `REG_COUNTER && !en_r);
    endsequence
    // write to index a then read of index b (may be the same), counter stopped
    sequence wr_rd(a, b);
        (reg_wr && reg_addr == a && !en_r && !$past(en_r))
            ##1 (reg_rd && reg_addr == b);
    endsequence
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_r == 16'h0000)
        else $error("read data not zero outside read");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > 4'hd |=>
        reg_rdata_r == 16'h0000) else $error("unmapped index read nonzero");
    AST_READBACK: assert property (wr_then_rd ##0 reg_addr >= 4'h5 &&
        reg_addr <= 4'hd |=>
        reg_rdata_r == $past(reg_wdata, 2)) else $error("readback mismatch");
    AST_PERIOD_BUFFER_VALID: assert property (reg_wr && reg_addr == `REG_PERIOD_BUF ##1
        reg_rd && reg_addr == `REG_CTRL_SIX |=> reg_rdata_r[0])
        else $error("period buffer valid not set");
    AST_QUIET: assert property (!en_r && !$past(en_r) && !$past(en_r, 2)
        |-> !top_event_r && !bottom_event_r && compare_event_r == 6'h00)
        else $error("event pulse while stopped");
    AST_FLAG_CLEAR: assert property (wr_rd(`REG_INT_FLAGS, `REG_INT_FLAGS)
        ##0 $past(reg_wdata) == 16'hffff |=> reg_rdata_r == 16'h0000)
        else $error("flags not cleared");
    AST_MAX: assert property (wr_rd(`REG_COUNTER, `REG_CTRL_SIX)
        |=> reg_rdata_r[`BIT_MAX] == ($past(reg_wdata, 2) == 16'hffff))
        else $error("max indication wrong");
    AST_HOLD: assert property (cnt_rd_pair |=>
        reg_rdata_r == $past(reg_rdata_r, 2)) else $error("counter moved");
endmodule

// ### tb/tb.sv
`include "timer_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg ref_clk = 1'b0; // 200 MHz clock
    reg resetn = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg event_count_in = 1'b0;
    reg event_dir_in = 1'b0;
    reg event_restart_in = 1'b0; // restart left idle
    wire [15:0] reg_rdata_r;
    wire top_event_r;
    wire bottom_event_r;
    wire [5:0] compare_event_r;
    integer miscompares = 0;
    integer comparisons = 0;
    integer tops = 0; // top pulses seen
    integer bots = 0; // bottom pulses seen
    integer cmps = 0; // compare pulse cycles seen
    always #2.5 ref_clk = ~ref_clk;
    // count event pulses
    always @(posedge ref_clk) begin
        if (top_event_r === 1'b1) begin
            tops = tops + 1;
        end
        if (bottom_event_r === 1'b1) begin
            bots = bots + 1;
        end
        if (compare_event_r !== 6'h00) begin
            cmps = cmps + 1;
        end
    end
    buffered_base_timer_counter buffered_base_timer_counter_i (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .event_count_in(event_count_in),
        .event_dir_in(event_dir_in), .event_restart_in(event_restart_in),
        .top_event_r(top_event_r), .bottom_event_r(bottom_event_r),
        .compare_event_r(compare_event_r));
    // compare and count
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        comparisons = comparisons + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // one write cycle, strobe left for the next caller
    task wr(input [3:0] a, input [15:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask
    task idle(input integer k);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (k) @(posedge ref_clk);
    endtask
    // read, data judged in the following cycle
    task rd(input [3:0] a, input [15:0] e);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        // read data stand only until the next edge
        #1 chk($sformatf("reg %h", a), e, reg_rdata_r);
        @(posedge ref_clk);
    endtask
    // exactly one divide-by-one tick
    task tick1;
        wr(`REG_CTRL_ONE, 16'h0001);
        wr(`REG_CTRL_ONE, 16'h0000);
        idle(2);
    endtask
    task pulses(input integer n);
        repeat (n) begin
            event_count_in <= 1'b1;
            @(posedge ref_clk);
            event_count_in <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task t_reset;
        rd(`REG_PERIOD, 16'hffff);
        rd(`REG_COUNTER, 16'h0000);
        rd(`REG_CTRL_SIX, 16'h0000);
        wr(4'hf, 16'h1234);
        rd(4'hf, 16'h0000);
        wr(`REG_CMP1, 16'h0009);
        rd(`REG_CMP1, 16'h0009);
        $display("test reset finished");
    endtask
    task t_wrap;
        wr(`REG_PERIOD, 16'h0003);
        wr(`REG_COUNTER, 16'h0003);
        wr(`REG_CTRL_FIVE, 16'h0002);
        wr(`REG_CMPBUF0, 16'h0005);
        wr(`REG_PERIOD_BUF, 16'h0007);
        rd(`REG_CTRL_SIX, 16'h0003);
        tick1;
        rd(`REG_COUNTER, 16'h0000);
        rd(`REG_PERIOD, 16'h0003);
        rd(`REG_CTRL_SIX, 16'h0003);
        rd(`REG_INT_FLAGS, 16'h0001);
        wr(`REG_COUNTER, 16'h0003);
        wr(`REG_CTRL_FIVE, 16'h0000);
        tick1;
        rd(`REG_PERIOD, 16'h0007);
        rd(`REG_CMP0, 16'h0005);
        rd(`REG_CTRL_SIX, 16'h0000);
        chk("top pulses", 16'd2, tops[15:0]);
        wr(`REG_INT_FLAGS, 16'hffff);
        rd(`REG_INT_FLAGS, 16'h0000);
        wr(`REG_COUNTER, 16'hffff);
        rd(`REG_CTRL_SIX, 16'h0010);
        $display("test wrap finished");
    endtask
    task t_down;
        wr(`REG_COUNTER, 16'h0000);
        wr(`REG_CTRL_FIVE, 16'h0001);
        tick1;
        rd(`REG_COUNTER, 16'h0007);
        rd(`REG_INT_FLAGS, 16'h0012);
        chk("bottom pulses", 16'd1, bots[15:0]);
        chk("compare pulses", 16'd1, cmps[15:0]);
        wr(`REG_COUNTER, 16'h0005);
        wr(`REG_CTRL_ONE, 16'h0001);
        wr(`REG_CTRL_FIVE, 16'h0000);
        wr(`REG_CTRL_ONE, 16'h0000);
        rd(`REG_COUNTER, 16'h0005);
        $display("test down finished");
    endtask
    task t_prio;
        wr(`REG_COUNTER, 16'h0014);
        wr(`REG_CTRL_ONE, 16'h0001);
        wr(`REG_COUNTER, 16'h0009);
        wr(`REG_CTRL_ONE, 16'h0000);
        rd(`REG_COUNTER, 16'h000a);
        $display("test priority finished");
    endtask
    task t_presc;
        wr(`REG_COUNTER, 16'h0000);
        wr(`REG_CTRL_ONE, 16'h0005);
        idle(5);
        wr(`REG_CTRL_ONE, 16'h0000);
        rd(`REG_COUNTER, 16'h0001);
        wr(`REG_CTRL_ONE, 16'h0005);
        idle(2);
        wr(`REG_CTRL_ONE, 16'h0000);
        rd(`REG_COUNTER, 16'h0001);
        $display("test prescaler finished");
    endtask
    task t_event;
        wr(`REG_COUNTER, 16'h0000);
        wr(`REG_EVT_CTRL, 16'h0001);
        wr(`REG_CTRL_ONE, 16'h0001);
        idle(3);
        pulses(3);
        wr(`REG_CTRL_ONE, 16'h0000);
        rd(`REG_COUNTER, 16'h0003);
        event_dir_in <= 1'b1;
        wr(`REG_EVT_CTRL, 16'h0003);
        wr(`REG_CTRL_ONE, 16'h0001);
        pulses(2);
        wr(`REG_CTRL_ONE, 16'h0000);
        rd(`REG_COUNTER, 16'h0001);
        wr(`REG_EVT_CTRL, 16'h0000);
        event_dir_in <= 1'b0;
        wr(`REG_COUNTER, 16'h0007);
        idle(10);
        rd(`REG_COUNTER, 16'h0007);
        rd(`REG_COUNTER, 16'h0007);
        $display("test event finished");
    endtask
    // report counts and verdict
    task conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_reset;
        t_wrap;
        t_down;
        t_prio;
        t_presc;
        t_event;
        conclude;
    end
    // watchdog well beyond the 130 or so cycles needed
    initial begin
        repeat (3000) @(posedge ref_clk);
        miscompares = miscompares + 1;
        conclude;
    end
endmodule
bind buffered_base_timer_counter timer_chk timer_chk_i (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .top_event_r(top_event_r),
    .bottom_event_r(bottom_event_r), .compare_event_r(compare_event_r));
